/* common/midmhe_pkg.sv */
// Purpose: Shared constants and types for the increment/decrement/move/halt executor.
// Assumes: APB slave with 8-bit byte address and 32-bit data, pclk at 20 MHz.
// Notes:   Every offset, field position and timing count, and the ACC, PC and memory reset values, live here.

package midmhe_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ          = 20;
  localparam int unsigned INSTR_CYCLE_NS   = 200;
  // Instruction cycle length in pclk cycles (exact at 20 MHz)
  localparam int unsigned INSTR_CYCLE_CLKS = (INSTR_CYCLE_NS * CLK_MHZ) / 1000;
  localparam int unsigned DIV_W            = 2;
  localparam logic [DIV_W-1:0] DIV_LAST    = DIV_W'(INSTR_CYCLE_CLKS - 1);

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_INSTR  = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ACC    = 8'h08;
  localparam logic [7:0] OFS_PC     = 8'h0C;
  localparam logic [7:0] OFS_CTRL   = 8'h10;
  localparam logic [7:0] OFS_WDT    = 8'h14;
  localparam logic [7:0] OFS_MEM    = 8'h80;

  // Instruction word fields
  localparam int unsigned INSTR_OP_LSB    = 0;
  localparam int unsigned INSTR_OPND_LSB  = 8;
  localparam int unsigned INSTR_JADDR_LSB = 16;
  localparam int unsigned PC_W            = 12;

  // Status bits
  localparam int unsigned ST_ZERO    = 0;
  localparam int unsigned ST_TIMEOUT = 1;
  localparam int unsigned ST_PDOWN   = 2;
  localparam int unsigned ST_BUSY    = 3;
  localparam int unsigned ST_HALTED  = 4;
  localparam int unsigned ST_ILLEGAL = 5;

  // Control bits
  localparam int unsigned CT_WAKE    = 0;
  localparam int unsigned CT_WDT_EN  = 1;
  localparam int unsigned CT_CLR_ILL = 2;

  // Data memory
  localparam int unsigned MEM_WORDS = 32;
  localparam int unsigned MEM_AW    = 5;

  // Reset values and watchdog terminal count
  localparam logic [7:0]      ACC_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST  = 12'h000;
  localparam logic [7:0]      MEM_RST = 8'h00;
  localparam logic [7:0]      WDT_MAX = 8'hFF;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    no_op                       = 4'b0000,
    decrement_memory_op         = 4'b0001,
    decrement_to_accumulator_op = 4'b0010,
    increment_memory_op         = 4'b0011,
    increment_to_accumulator_op = 4'b0100,
    halt_op                     = 4'b0101,
    jump_op                     = 4'b0110,
    move_op                     = 4'b0111,
    move_immediate_op           = 4'b1000
  } midmhe_op_t;

  typedef enum logic [1:0] {
    ALU_PASS = 2'b00,
    ALU_INC  = 2'b01,
    ALU_DEC  = 2'b10
  } midmhe_alu_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_JUMP = 2'b01,
    S_HALT = 2'b10
  } midmhe_state_t;

endpackage

/* hw/midmhe_alu.sv */
// Purpose: Byte incrementer/decrementer with zero detect.
// Assumes: Purely combinational; the caller registers the result.
// Notes:   Wraps modulo 256 in both directions.

`timescale 1ns/1ps
`default_nettype none

module midmhe_alu (
  input  wire logic [7:0]             operand,
  input  wire midmhe_pkg::midmhe_alu_t mode,
  output logic [7:0]                  result,
  output logic                        zero
);

  // ****************************************************************
  // Datapath
  // ****************************************************************
  wire logic [7:0] inc_val = operand + 8'h01;
  wire logic [7:0] dec_val = operand - 8'h01;

  // Select per mode; pass covers the move instructions
  assign result = (mode == midmhe_pkg::ALU_INC) ? inc_val :
                  (mode == midmhe_pkg::ALU_DEC) ? dec_val : operand;
  // Zero exactly when the 8-bit result is all zeros
  assign zero   = (result == 8'h00);

endmodule

`default_nettype wire

/* hw/midmhe_exec.sv */
// Purpose: Executes the decrement, increment, move, jump and halt instructions.
// Assumes: Software posts one instruction at a time over APB; pclk at 20 MHz.
// Notes:   One instruction cycle is four pclk; a halt stops the cycle divider.

`timescale 1ns/1ps
`default_nettype none

module midmhe_exec (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             core_clk_en
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  midmhe_pkg::midmhe_state_t state_q;
  midmhe_pkg::midmhe_state_t state_d;

  logic [midmhe_pkg::DIV_W-1:0] div_q;
  logic                         pend_q;
  logic [3:0]                   op_q;
  logic [7:0]                   opnd_q;
  logic [midmhe_pkg::PC_W-1:0]  jaddr_q;
  logic [7:0]                   acc_q;
  logic [midmhe_pkg::PC_W-1:0]  pc_q;
  logic                         zero_q;
  logic                         timeout_q;
  logic                         pdown_q;
  logic                         illegal_q;
  logic                         wdt_en_q;
  logic [7:0]                   wdt_pre_q;
  logic [7:0]                   wdt_cnt_q;
  logic                         pready_q;
  logic                         pslverr_q;
  logic [31:0]                  prdata_q;
  logic                         clk_en_q;
  logic [7:0]                   mem_q [midmhe_pkg::MEM_WORDS];

  midmhe_pkg::midmhe_alu_t alu_mode;
  logic [7:0]              alu_in;
  logic [7:0]              alu_res;
  logic                    alu_zero;

  // ****************************************************************
  // Instruction cycle divider
  // ****************************************************************
  // Divider is held at zero while halted; the core clock gate itself follows the sequencer state
  wire logic halted = (state_q == midmhe_pkg::S_HALT);
  wire logic tick   = ~halted & (div_q == midmhe_pkg::DIV_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
    end else if (halted) begin
      div_q <= '0;
    end else begin
      div_q <= tick ? '0 : div_q + 1'b1;
    end
  end

  // ****************************************************************
  // Opcode decode
  // ****************************************************************
  wire logic op_dec_mem = (op_q == midmhe_pkg::decrement_memory_op);
  wire logic op_dec_acc = (op_q == midmhe_pkg::decrement_to_accumulator_op);
  wire logic op_inc_mem = (op_q == midmhe_pkg::increment_memory_op);
  wire logic op_inc_acc = (op_q == midmhe_pkg::increment_to_accumulator_op);
  wire logic op_halt    = (op_q == midmhe_pkg::halt_op);
  wire logic op_jump    = (op_q == midmhe_pkg::jump_op);
  wire logic op_mov_mem = (op_q == midmhe_pkg::move_op);
  wire logic op_mov_imm = (op_q == midmhe_pkg::move_immediate_op);
  wire logic op_nop     = (op_q == midmhe_pkg::no_op);
  wire logic op_legal   = op_dec_mem | op_dec_acc | op_inc_mem | op_inc_acc | op_halt
                        | op_jump | op_mov_mem | op_mov_imm | op_nop;

  // Execute edge: idle, an instruction waiting, and the cycle tick
  wire logic exec       = tick & pend_q & (state_q == midmhe_pkg::S_IDLE);
  wire logic busy       = pend_q | (state_q == midmhe_pkg::S_JUMP);

  // Only memory-destination ops write the array; accumulator ops never do
  wire logic ex_mem_wr  = exec & (op_dec_mem | op_inc_mem);
  wire logic ex_acc_wr  = exec & (op_dec_acc | op_inc_acc | op_mov_mem | op_mov_imm);
  wire logic ex_zero_wr = exec & (op_dec_mem | op_dec_acc | op_inc_mem | op_inc_acc);
  wire logic ex_halt    = exec & op_halt;
  wire logic ex_jump    = exec & op_jump;

  // ****************************************************************
  // Arithmetic
  // ****************************************************************
  wire logic [midmhe_pkg::MEM_AW-1:0] ex_addr = opnd_q[midmhe_pkg::MEM_AW-1:0];
  wire logic [7:0]                    mem_rd  = mem_q[ex_addr];

  assign alu_in   = op_mov_imm ? opnd_q : mem_rd;
  assign alu_mode = (op_dec_mem | op_dec_acc) ? midmhe_pkg::ALU_DEC :
                    (op_inc_mem | op_inc_acc) ? midmhe_pkg::ALU_INC : midmhe_pkg::ALU_PASS;

  midmhe_alu u_alu (
    .operand (alu_in),
    .mode    (alu_mode),
    .result  (alu_res),
    .zero    (alu_zero)
  );

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire logic       acc_phase = psel & penable;
  wire logic       hit_instr = (paddr == midmhe_pkg::OFS_INSTR);
  wire logic       hit_stat  = (paddr == midmhe_pkg::OFS_STATUS);
  wire logic       hit_acc   = (paddr == midmhe_pkg::OFS_ACC);
  wire logic       hit_pc    = (paddr == midmhe_pkg::OFS_PC);
  wire logic       hit_ctrl  = (paddr == midmhe_pkg::OFS_CTRL);
  wire logic       hit_wdt   = (paddr == midmhe_pkg::OFS_WDT);
  wire logic       hit_mem   = paddr[7] & (paddr[1:0] == 2'b00);
  wire logic [midmhe_pkg::MEM_AW-1:0] bus_idx = paddr[midmhe_pkg::MEM_AW+1:2];
  wire logic       mapped    = hit_instr | hit_stat | hit_acc | hit_pc | hit_ctrl
                             | hit_wdt | hit_mem;
  // No new instruction can be taken while halted
  wire logic       bad_acc   = ~mapped | (pwrite & hit_instr & halted);
  // Writes wait while an instruction is in flight so the bus never races it
  wire logic       wr_stall  = pwrite & busy;
  wire logic       pready_d  = acc_phase & ~pready_q & ~wr_stall;
  wire logic       bus_wr    = acc_phase & pready_q & pwrite & ~pslverr_q;

  wire logic       wr_instr  = bus_wr & hit_instr;
  wire logic       wr_acc    = bus_wr & hit_acc;
  wire logic       wr_ctrl   = bus_wr & hit_ctrl;
  wire logic       wr_mem    = bus_wr & hit_mem;
  wire logic       wake      = wr_ctrl & pwdata[midmhe_pkg::CT_WAKE];
  wire logic       clr_ill   = wr_ctrl & pwdata[midmhe_pkg::CT_CLR_ILL];

  wire logic [31:0] status_rd = {26'h000_0000, illegal_q, halted, busy, pdown_q,
                                 timeout_q, zero_q};
  wire logic [31:0] rd_mux    = hit_instr ? {4'h0, jaddr_q, opnd_q, 4'h0, op_q} :
                                hit_stat  ? status_rd :
                                hit_acc   ? {24'h00_0000, acc_q} :
                                hit_pc    ? {20'h0_0000, pc_q} :
                                hit_ctrl  ? {30'h0000_0000, wdt_en_q, 1'b0} :
                                hit_wdt   ? {16'h0000, wdt_cnt_q, wdt_pre_q} :
                                hit_mem   ? {24'h00_0000, mem_q[bus_idx]} : 32'h0000_0000;

  // Answer one cycle into the access phase; data and error captured with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pready_d & bad_acc;
      prdata_q  <= (pready_d & ~pwrite & ~bad_acc) ? rd_mux : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Instruction intake
  // ****************************************************************
  // Posting while busy is stalled above, so the slot is never overwritten
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q  <= 1'b0;
      op_q    <= 4'h0;
      opnd_q  <= 8'h00;
      jaddr_q <= midmhe_pkg::PC_RST;
    end else if (wr_instr) begin
      pend_q  <= 1'b1;
      op_q    <= pwdata[midmhe_pkg::INSTR_OP_LSB +: 4];
      opnd_q  <= pwdata[midmhe_pkg::INSTR_OPND_LSB +: 8];
      jaddr_q <= pwdata[midmhe_pkg::INSTR_JADDR_LSB +: midmhe_pkg::PC_W];
    end else if (exec) begin
      pend_q  <= 1'b0;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Jump spends a dummy cycle; halt parks until software wakes the core
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      midmhe_pkg::S_IDLE: begin
        if (ex_jump) begin
          state_d = midmhe_pkg::S_JUMP;
        end else if (ex_halt) begin
          state_d = midmhe_pkg::S_HALT;
        end
      end
      midmhe_pkg::S_JUMP: begin
        if (tick) begin
          state_d = midmhe_pkg::S_IDLE;
        end
      end
      midmhe_pkg::S_HALT: begin
        if (wake) begin
          state_d = midmhe_pkg::S_IDLE;
        end
      end
      default: begin
        state_d = midmhe_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= midmhe_pkg::S_IDLE;
      clk_en_q <= 1'b1;
    end else begin
      state_q  <= state_d;
      clk_en_q <= (state_d != midmhe_pkg::S_HALT);
    end
  end

  // ****************************************************************
  // Accumulator and program counter
  // ****************************************************************
  // While halted there is no exec, so the counter holds; only a bus write can still load the accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= midmhe_pkg::ACC_RST;
    end else if (ex_acc_wr) begin
      acc_q <= alu_res;
    end else if (wr_acc) begin
      acc_q <= pwdata[7:0];
    end
  end

  // Every single-cycle op advances the counter; jump loads the target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= midmhe_pkg::PC_RST;
    end else if (ex_jump) begin
      pc_q <= jaddr_q;
    end else if (exec) begin
      pc_q <= pc_q + 12'h001;
    end
  end

  // ****************************************************************
  // Flags
  // ****************************************************************
  // Only inc/dec touch Z; moves, jump and halt leave it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_q <= 1'b0;
    end else if (ex_zero_wr) begin
      zero_q <= alu_zero;
    end
  end

  // Power-down flag stays set through wake; only reset clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pdown_q <= 1'b0;
    end else if (ex_halt) begin
      pdown_q <= 1'b1;
    end
  end

  // Unknown opcodes run as a no-op and leave a sticky mark; set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      illegal_q <= 1'b0;
    end else if (exec & ~op_legal) begin
      illegal_q <= 1'b1;
    end else if (clr_ill) begin
      illegal_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  // Counts instruction cycles through an 8-bit prescaler while enabled
  wire logic wdt_step = tick & wdt_en_q;
  wire logic pre_wrap = (wdt_pre_q == midmhe_pkg::WDT_MAX);
  wire logic wdt_tout = wdt_step & pre_wrap & (wdt_cnt_q == midmhe_pkg::WDT_MAX);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_en_q <= 1'b0;
    end else if (wr_ctrl) begin
      wdt_en_q <= pwdata[midmhe_pkg::CT_WDT_EN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_pre_q <= 8'h00;
      wdt_cnt_q <= 8'h00;
    end else if (ex_halt) begin
      wdt_pre_q <= 8'h00;
      wdt_cnt_q <= 8'h00;
    end else if (wdt_step) begin
      wdt_pre_q <= wdt_pre_q + 8'h01;
      wdt_cnt_q <= pre_wrap ? wdt_cnt_q + 8'h01 : wdt_cnt_q;
    end
  end

  // A time-out in the halt cycle itself still wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_q <= 1'b0;
    end else if (wdt_tout) begin
      timeout_q <= 1'b1;
    end else if (ex_halt) begin
      timeout_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Data memory
  // ****************************************************************
  // One flop byte per entry; executor and bus never write the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < midmhe_pkg::MEM_WORDS; gi++) begin : g_mem
      // Entry index cut to the address width on purpose
      localparam logic [midmhe_pkg::MEM_AW-1:0] ENTRY = midmhe_pkg::MEM_AW'(gi);
      wire logic hit_ex  = ex_mem_wr & (ex_addr == ENTRY);
      wire logic hit_bus = wr_mem & (bus_idx == ENTRY);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem_q[gi] <= midmhe_pkg::MEM_RST;
        end else if (hit_ex) begin
          mem_q[gi] <= alu_res;
        end else if (hit_bus) begin
          mem_q[gi] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign core_clk_en = clk_en_q;

endmodule

`default_nettype wire

/* verif/midmhe_exec_assertions.sv */
// Purpose: Port-level checks of the executor's APB slave and core clock gate.
// Assumes: Single pclk domain, presetn asynchronous and active low.
// Notes:   Bound from the bench top; unaligned addresses are left unjudged.
`timescale 1ns/1ps
`default_nettype none
module midmhe_exec_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        core_clk_en
);
  // ****************************************************************
  // Helpers and properties
  // ****************************************************************
  // Aligned word inside the map, and a write to the instruction slot
  wire logic listed = (paddr[1:0] == 2'b00) && ((paddr <= 8'h14) || paddr[7]);
  wire logic instr_wr = pwrite && (paddr == midmhe_pkg::OFS_INSTR);
  logic [1:0] wake_age_q;
  // Age of the last wake write; saturates so an old wake never looks fresh
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_age_q <= 2'h3;
    end else if (pready && pwrite && paddr == midmhe_pkg::OFS_CTRL && pwdata[0]) begin
      wake_age_q <= 2'h0;
    end else if (wake_age_q != 2'h3) begin
      wake_age_q <= wake_age_q + 2'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside a completion");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_read_one_wait: assert property ($rose(penable) && psel && !pwrite |=> pready)
    else $error("read not answered after one wait state");
  chk_write_bounded: assert property ($rose(penable) && psel && pwrite |-> ##[1:16] pready)
    else $error("write stalled too long");
  chk_unmapped_err: assert property (pready && paddr[1:0] == 2'b00 && !listed |-> pslverr)
    else $error("unmapped access without error");
  chk_mapped_no_err: assert property (pready && listed && !instr_wr |-> !pslverr)
    else $error("mapped access flagged as error");
  chk_halt_refuses: assert property (pready && instr_wr && !core_clk_en && !$past(core_clk_en) |-> pslverr)
    else $error("instruction accepted while halted");
  chk_wake_cause: assert property ($rose(core_clk_en) |-> wake_age_q <= 2'h1)
    else $error("core clock restarted without a wake write");
  cov_halt: cover property ($fell(core_clk_en));
  cov_wake: cover property ($rose(core_clk_en));
  cov_err: cover property (pready && pslverr);
endmodule
`default_nettype wire

/* verif/tb_mcu_inc_dec_move_halt_exec.sv */
// Purpose: Self-checking bench for the increment/decrement/move/halt executor.
// Assumes: APB master leaves one idle cycle between transfers.
// Notes:   Expectations come from a byte-level model kept in the bench.
`timescale 1ns/1ps
`default_nettype none
module tb_mcu_inc_dec_move_halt_exec;
  // ****************************************************************
  // Signals, model state and stimulus tables
  // ****************************************************************
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        core_clk_en;
  int          error_cnt;
  int          tests_run;
  int          seed;
  int          waits;
  int          gap [2];
  logic [31:0] rdat;
  logic        err;
  logic [7:0]  mem [32];
  logic [7:0]  m_acc;
  logic [11:0] m_pc;
  logic        m_z;
  logic        m_pdf;
  logic        m_halt;
  logic [3:0]  ops [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h6};
  logic [3:0]  c_op [7] = '{4'h2, 4'h8, 4'h3, 4'h7, 4'h6, 4'h1, 4'h4};
  logic [7:0]  c_ar [7] = '{8'h00, 8'h00, 8'h02, 8'h05, 8'h00, 8'h01, 8'h02};

  midmhe_exec dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
                     .prdata, .pready, .pslverr, .core_clk_en);

  // Free-running 20 MHz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Cut a hang short; the full run needs far less than this
  initial begin
    #(50 * 40000);
    error_cnt++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    report_and_stop();
  end

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is sampled high or 40 cycles pass
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er, output int w);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 40);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    cmp(w < 40, 1'b1, "no ready");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdat, err, waits);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string s);
    apb(1'b0, a, 32'h0000_0000, rdat, err, waits);
    cmp(rdat, e, s);
  endtask

  function automatic logic [31:0] st();
    return {27'h0, m_halt, 1'b0, m_pdf, 1'b0, m_z};
  endfunction

  // Expected 8-bit result of an operation on byte v
  function automatic logic [7:0] res(input logic [3:0] op, input logic [7:0] v,
                                     input logic [7:0] imm);
    case (op)
      4'h1, 4'h2: res = v - 8'h01;
      4'h3, 4'h4: res = v + 8'h01;
      4'h8: res = imm;
      default: res = v;
    endcase
  endfunction

  // Post one instruction, update the model, then compare status, accumulator, counter and the addressed memory byte
  task automatic run(input logic [3:0] op, input logic [7:0] opnd, input logic [11:0] tgt);
    logic [7:0] r;
    r = res(op, mem[opnd[4:0]], opnd);
    wr(midmhe_pkg::OFS_INSTR, {4'h0, tgt, opnd, 4'h0, op});
    if (op == 4'h1 || op == 4'h3) mem[opnd[4:0]] = r;
    if (op inside {4'h2, 4'h4, 4'h7, 4'h8}) m_acc = r;
    if (op inside {4'h1, 4'h2, 4'h3, 4'h4}) m_z = (r == 8'h00);
    m_pc = (op == 4'h6) ? tgt : m_pc + 12'h001;
    m_pdf = m_pdf | (op == 4'h5);
    m_halt = (op == 4'h5);
    for (int n = 0; n < 20 && (n == 0 || rdat[3] !== 1'b0); n++) begin
      apb(1'b0, midmhe_pkg::OFS_STATUS, 32'h0000_0000, rdat, err, waits);
    end
    cmp(rdat, st(), "status");
    rdc(midmhe_pkg::OFS_ACC, {24'h0, m_acc}, "acc");
    rdc(midmhe_pkg::OFS_PC, {20'h0, m_pc}, "pc");
    rdc(midmhe_pkg::OFS_MEM + {1'b0, opnd[4:0], 2'b00}, {24'h0, mem[opnd[4:0]]}, "mem");
  endtask

  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {m_acc, m_pc, m_z, m_pdf, m_halt} = '0;
    presetn = 1'b0;
    seed = 32;
    error_cnt = 0;
    tests_run = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc(midmhe_pkg::OFS_STATUS, 32'h0000_0000, "reset status");
    for (int i = 0; i < 32; i++) begin
      mem[i] = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'hFF : 8'($random(seed));
      wr(midmhe_pkg::OFS_MEM + 8'(4 * i), {24'h0, mem[i]});
    end
    wr(midmhe_pkg::OFS_CTRL, 32'h0000_0002);
    for (int i = 0; i < 7; i++) begin
      run(c_op[i], c_ar[i], 12'($random(seed)));
    end
    // Same divider phase for both runs, so only the dummy cycle differs
    for (int k = 0; k < 2; k++) begin
      wr(midmhe_pkg::OFS_INSTR, 32'h0000_0000);
      wr(midmhe_pkg::OFS_INSTR, k ? 32'h0123_0006 : 32'h0000_0000);
      wr(midmhe_pkg::OFS_ACC, 32'h0000_005A);
      gap[k] = waits;
      m_pc = k ? 12'h123 : m_pc + 12'h002;
      m_acc = 8'h5A;
    end
    cmp(32'(gap[1] - gap[0]), 32'(midmhe_pkg::INSTR_CYCLE_CLKS), "jump length");
    for (int i = 0; i < 40; i++) begin
      run(ops[$unsigned($random(seed)) % 7], 8'($random(seed)), 12'($random(seed)));
    end
    wr(midmhe_pkg::OFS_STATUS, 32'hFFFF_FFFF);
    rdc(midmhe_pkg::OFS_STATUS, st(), "status write");
    apb(1'b0, 8'h18, 32'h0000_0000, rdat, err, waits);
    cmp(err, 1'b1, "unmapped error");
    cmp(rdat, 32'h0000_0000, "unmapped data");
    run(4'h5, 8'h03, 12'h000);
    cmp(core_clk_en, 1'b0, "clock gate");
    rdc(midmhe_pkg::OFS_WDT, 32'h0000_0000, "wdt cleared");
    apb(1'b1, midmhe_pkg::OFS_INSTR, 32'h0000_0303, rdat, err, waits);
    cmp(err, 1'b1, "instr while halted");
    rdc(midmhe_pkg::OFS_MEM + 8'h0C, {24'h0, mem[3]}, "mem kept");
    wr(midmhe_pkg::OFS_CTRL, 32'h0000_0001);
    m_halt = 1'b0;
    repeat (3) @(posedge pclk);
    cmp(core_clk_en, 1'b1, "wake");
    run(4'h3, 8'h03, 12'h000);
    report_and_stop();
  end
endmodule

bind midmhe_exec midmhe_exec_assertions chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .core_clk_en);
`default_nettype wire
